// File: hw/tbu_params.svh
// Purpose: offsets, field positions, reset values and counts of the timer
// Assumes: 32-bit APB data, one register per aligned word
// Notes: definitions only
`ifndef TBU_PARAMS_SVH
`define TBU_PARAMS_SVH

// register byte offsets
`define TBU_AW 5
`define TBU_OFS_CTRL 5'h00
`define TBU_OFS_COUNT 5'h04
`define TBU_OFS_MODULO 5'h08
`define TBU_OFS_CH0_CTL 5'h0C
`define TBU_OFS_CH1_CTL 5'h10
`define TBU_OFS_CH0_VAL 5'h14
`define TBU_OFS_CH1_VAL 5'h18

// timer control register fields
`define TBU_CTRL_FLAG 7
`define TBU_CTRL_IE 6
`define TBU_CTRL_HALT 5
`define TBU_CTRL_RST 4

// channel control register: flag bit, low byte holds the whole field set
`define TBU_CH_FLAG 7

// reset values and sizes
`define TBU_MOD_RST 16'hFFFF
`define TBU_PSC_W 6
`define TBU_RATE_OFF 3'h7
`define TBU_ELS_CLEAR 2'h2
`define TBU_ELS_TOGGLE 2'h1
`define TBU_ELS_SET 2'h3

`endif

// File: hw/tbu_pkg.sv
// Purpose: types shared by the timer modules
// Assumes: tbu_params.svh supplies the numbers
// Notes: no constants here beyond types
`include "tbu_params.svh"
package tbu_pkg;

    // one channel control byte, msb first
    typedef struct packed {
        logic flag;        // chan_event_flag
        logic irq_en;      // chan_irq_enable
        logic buf_mode;    // chan0_buffered_mode, always 0 on channel 1
        logic unbuf_mode;  // chan_unbuffered_mode
        logic els_hi;      // edge_level_sel_hi
        logic els_lo;      // edge_level_sel_lo
        logic tov;         // toggle_on_wrap
        logic full_duty;   // full_duty_force
    } tbu_chctl_s;

    // whole state of the main timer
    typedef struct packed {
        logic [15:0] cnt;            // counter
        logic [15:0] modulo;         // modulo_limit_high/low
        logic [2:0] rate;            // prescale_select
        logic halt;                  // counter_halt
        logic wrap_flag;             // wrap_flag
        logic wrap_ie;               // wrap_irq_enable
        tbu_chctl_s [1:0] ctl;       // chan control/status
        logic [1:0][15:0] val;       // chan_value_high/low
        logic [1:0] pin_lvl;         // driven channel pin levels
        logic moved;                 // counter changed last cycle
        logic act_sel;               // linked mode: active value channel
        logic last_wr;               // linked mode: channel written last
        logic [31:0] rdata;          // apb read data
    } tbu_state_s;

    // prescaler divider state
    typedef struct packed {
        logic [`TBU_PSC_W-1:0] div;
    } tbu_psc_s;

    // pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tbu_sync_s;

endpackage

// File: hw/tbu_prescaler.sv
// Purpose: seven-rate divider giving the counter's enable pulse
// Assumes: one clock, synchronous active-low reset
// Notes: rate 7 gives no pulse at all
`timescale 1ns/1ps
`default_nettype none
`include "tbu_params.svh"
module tbu_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic run,
    input wire logic [2:0] rate,
    output logic tick
);
    tbu_pkg::tbu_psc_s r;       // divider state
    tbu_pkg::tbu_psc_s next_r;  // its next value
    logic [`TBU_PSC_W-1:0] mask; // low bits that must all be ones

    // divide by 2**rate: pulse when the masked low bits are all ones
    always_comb begin
        mask = `TBU_PSC_W'((7'h01 << rate) - 7'h01);
        tick = run & (rate != `TBU_RATE_OFF) & (&(r.div | ~mask));
        next_r = r;
        if (!rst_n || clear) begin
            next_r.div = '0;
        end else if (run) begin
            next_r.div = r.div + `TBU_PSC_W'(1);
        end
    end

    // register the divider
    always_ff @(posedge clk) begin
        r <= next_r;
    end
endmodule
`default_nettype wire

// File: hw/tbu_edge_sync.sv
// Purpose: two-flop synchroniser and edge detector for one channel pin
// Assumes: pin is asynchronous to clk
// Notes: edges are seen from the second and third flops only
`timescale 1ns/1ps
`default_nettype none
module tbu_edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    tbu_pkg::tbu_sync_s r;       // s1, s2 synchronise; s3 remembers
    tbu_pkg::tbu_sync_s next_r;  // next value

    // the first flop feeds only the second, so metastability stays put
    always_comb begin
        rise = r.s2 & ~r.s3;
        fall = ~r.s2 & r.s3;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (!rst_n) begin
            next_r = '0;
        end
    end

    // register the chain
    always_ff @(posedge clk) begin
        r <= next_r;
    end
endmodule
`default_nettype wire

// File: hw/tbu_timer.sv
// Purpose: two-channel capture/compare timer with an APB register port
// Assumes: 25 MHz clk, synchronous active-low reset, zero-wait APB slave
// Notes: channel pins are split into in, out and output enable
`timescale 1ns/1ps
`default_nettype none
`include "tbu_params.svh"

module tbu_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TBU_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chan0_pin_in,
    output logic chan0_pin_out,
    output logic chan0_pin_oe,
    input wire logic chan1_pin_in,
    output logic chan1_pin_out,
    output logic chan1_pin_oe,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    tbu_pkg::tbu_state_s r;       // registered state
    tbu_pkg::tbu_state_s next_r;  // next state
    logic [1:0] pin_in;           // raw pins, indexed by channel
    logic [1:0] rise;             // synchronised rising edges
    logic [1:0] fall;             // synchronised falling edges
    logic tick;                   // prescaled counter enable
    logic wr;                     // apb write access phase
    logic mapped;                 // address hits a register
    logic cnt_clear;              // counter reset bit written as 1
    logic wrap;                   // counter reaches modulo on this tick
    logic linked;                 // channels 0 and 1 form one buffered channel
    logic [1:0] oc;               // channel is an output compare
    logic [1:0] ic;               // channel is an input capture
    logic [1:0] chan_on;          // channel control register honoured

    // pins by channel index
    assign pin_in = {chan1_pin_in, chan0_pin_in};

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and prescaler

    // one synchroniser per channel pin
    // two flops, then the detector
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            tbu_edge_sync u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .pin(pin_in[gi]),
                .rise(rise[gi]),
                .fall(fall[gi])
            );
        end
    endgenerate

    // counter clock enable; halt freezes the divider too
    // one time base for both channels
    tbu_prescaler u_psc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(cnt_clear),
        .run(~r.halt),
        .rate(r.rate),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // bus decode and mode decode

    // zero-wait slave; unmapped addresses answer with an error
    // misaligned offsets match nothing
    always_comb begin
        wr = psel & penable & pwrite;
        mapped = (paddr == `TBU_OFS_CTRL) | (paddr == `TBU_OFS_COUNT)
               | (paddr == `TBU_OFS_MODULO) | (paddr == `TBU_OFS_CH0_CTL)
               | (paddr == `TBU_OFS_CH1_CTL) | (paddr == `TBU_OFS_CH0_VAL)
               | (paddr == `TBU_OFS_CH1_VAL);
        pready = 1'b1;
        pslverr = psel & penable & ~mapped;
        prdata = r.rdata;

        cnt_clear = wr & (paddr == `TBU_OFS_CTRL) & pwdata[`TBU_CTRL_RST];
        // wrap pulses on a tick only
        wrap = tick & (r.cnt == r.modulo);
        linked = r.ctl[0].buf_mode;
    end

    // channel modes from mode and edge/level bits
    // channel 1 loses out only when linked
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // channel 1 control has no say while linked
            chan_on[i] = (i == 0) | ~linked;

            // buffered wins over unbuffered; input capture needs both clear
            oc[i] = chan_on[i] & (r.ctl[i].buf_mode | r.ctl[i].unbuf_mode)
                  & (r.ctl[i].els_hi | r.ctl[i].els_lo);
            ic[i] = chan_on[i] & ~r.ctl[i].buf_mode & ~r.ctl[i].unbuf_mode
                  & (r.ctl[i].els_hi | r.ctl[i].els_lo);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    // bus effects first, hardware events after, so an event wins a clear
    always_comb begin
        logic [15:0] cmpv;
        logic cap;
        logic mat;
        logic force_hi;
        cmpv = '0;
        cap = 1'b0;
        mat = 1'b0;
        force_hi = 1'b0;

        // default: keep every field except moved, which clears
        next_r = r;
        next_r.moved = 1'b0;


        // read data is latched in the setup cycle; reading has no side effect
        // a count read changes nothing
        if (psel & ~penable & ~pwrite) begin
            next_r.rdata = '0;
            unique case (paddr)
                `TBU_OFS_CTRL: begin
                    next_r.rdata[7:0] = {r.wrap_flag, r.wrap_ie, r.halt,
                                         2'b00, r.rate};
                end
                `TBU_OFS_COUNT: begin
                    next_r.rdata[15:0] = r.cnt;
                end
                `TBU_OFS_MODULO: begin
                    next_r.rdata[15:0] = r.modulo;
                end
                `TBU_OFS_CH0_CTL: begin
                    next_r.rdata[7:0] = r.ctl[0];
                end
                `TBU_OFS_CH1_CTL: begin
                    next_r.rdata[7:0] = r.ctl[1];
                end
                `TBU_OFS_CH0_VAL: begin
                    next_r.rdata[15:0] = r.val[0];
                end
                `TBU_OFS_CH1_VAL: begin
                    next_r.rdata[15:0] = r.val[1];
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end

        // register writes in the access phase
        // a written 1 keeps a flag
        if (wr) begin
            unique case (paddr)
                `TBU_OFS_CTRL: begin
                    // writing 1 to the flag does nothing, 0 clears it
                    next_r.wrap_flag = r.wrap_flag & pwdata[`TBU_CTRL_FLAG];
                    next_r.wrap_ie = pwdata[`TBU_CTRL_IE];
                    next_r.halt = pwdata[`TBU_CTRL_HALT];
                    next_r.rate = pwdata[2:0];
                end
                `TBU_OFS_MODULO: begin
                    next_r.modulo = pwdata[15:0];
                end
                `TBU_OFS_CH0_CTL: begin
                    next_r.ctl[0] = tbu_pkg::tbu_chctl_s'(pwdata[7:0]);
                    next_r.ctl[0].flag = r.ctl[0].flag & pwdata[`TBU_CH_FLAG];
                end
                `TBU_OFS_CH1_CTL: begin
                    next_r.ctl[1] = tbu_pkg::tbu_chctl_s'(pwdata[7:0]);
                    next_r.ctl[1].flag = r.ctl[1].flag & pwdata[`TBU_CH_FLAG];
                    // the buffered bit exists on channel 0 only
                    next_r.ctl[1].buf_mode = 1'b0;
                end
                `TBU_OFS_CH0_VAL: begin
                    next_r.val[0] = pwdata[15:0];
                    next_r.last_wr = 1'b0;
                end
                `TBU_OFS_CH1_VAL: begin
                    next_r.val[1] = pwdata[15:0];
                    next_r.last_wr = linked;
                end
                default: begin
                    next_r.rdata = r.rdata;
                end
            endcase
        end

        // counter: reset bit clears it even while halted
        if (cnt_clear) begin
            next_r.cnt = '0;
            next_r.moved = 1'b1;
        end else if (tick) begin
            // wrap to zero on the tick after reaching the modulo value
            next_r.cnt = wrap ? 16'h0000 : r.cnt + 16'h0001;
            next_r.moved = 1'b1;
        end

        // wrap flag, set wins over a same-cycle clear
        if (wrap) begin
            next_r.wrap_flag = 1'b1;
            // linked pair hands control to the channel written last
            next_r.act_sel = linked & r.last_wr;
        end

        // outside linked mode channel 0 owns the output from the start
        if (!linked) begin
            next_r.act_sel = 1'b0;
            next_r.last_wr = 1'b0;
        end

        // per channel capture and compare
        for (int i = 0; i < 2; i++) begin
            // linked channel 0 compares against the active value register
            cmpv = (i == 0 && linked) ? r.val[r.act_sel] : r.val[i];

            // capture on every qualifying edge, flag state does not matter
            cap = ic[i] & ((r.ctl[i].els_lo & rise[i])
                         | (r.ctl[i].els_hi & fall[i]));

            // match once per counter value, against the live register
            mat = oc[i] & r.moved & (r.cnt == cmpv);
            force_hi = r.ctl[i].tov & r.ctl[i].full_duty
                     & ({r.ctl[i].els_hi, r.ctl[i].els_lo} == `TBU_ELS_CLEAR);

            // capture overwrites
            if (cap) begin
                next_r.val[i] = r.cnt;
            end
            if (cap | mat) begin
                next_r.ctl[i].flag = 1'b1;
            end

            // pin level
            if (!r.ctl[i].els_hi && !r.ctl[i].els_lo) begin
                // output preset: unbuffered bit picks the initial level
                next_r.pin_lvl[i] = ~r.ctl[i].unbuf_mode;
            end else if (oc[i]) begin
                if (wrap && r.ctl[i].tov) begin
                    // wrap beats a compare in the same cycle
                    next_r.pin_lvl[i] = force_hi | ~r.pin_lvl[i];
                end else if (mat && !force_hi) begin
                    unique case ({r.ctl[i].els_hi, r.ctl[i].els_lo})
                        `TBU_ELS_TOGGLE: begin
                            next_r.pin_lvl[i] = ~r.pin_lvl[i];
                        end
                        `TBU_ELS_CLEAR: begin
                            next_r.pin_lvl[i] = 1'b0;
                        end
                        `TBU_ELS_SET: begin
                            next_r.pin_lvl[i] = 1'b1;
                        end
                        default: begin
                            next_r.pin_lvl[i] = r.pin_lvl[i];
                        end
                    endcase
                end else if (force_hi) begin
                    // held high from the next cycle while full duty stands
                    next_r.pin_lvl[i] = 1'b1;
                end
            end
        end

        // reset: everything but the channel value registers
        // synchronous reset
        if (!rst_n) begin
            next_r = '0;
            next_r.modulo = `TBU_MOD_RST;
            next_r.pin_lvl = 2'b11;
            next_r.val = r.val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    // single register for the whole state
    // value fields ignore reset
    always_ff @(posedge clk) begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    // pins driven only while their channel compares; channel 1 freed when linked
    always_comb begin
        chan0_pin_out = r.pin_lvl[0];
        chan1_pin_out = r.pin_lvl[1];

        // enables follow mode bits
        chan0_pin_oe = oc[0];
        chan1_pin_oe = oc[1];
        // level request while any enabled flag stands; channel 1's counts only when not linked
        irq = (r.wrap_flag & r.wrap_ie)
            | (r.ctl[0].flag & r.ctl[0].irq_en)
            | (r.ctl[1].flag & r.ctl[1].irq_en & chan_on[1]);
    end

endmodule
`default_nettype wire

// File: tb/tbu_timer_props.sv
// Purpose: port-level checks for tbu_timer
// Assumes: one clock, synchronous active-low reset
// Notes: channel control fields are shadowed from apb writes
`timescale 1ns/1ps
`default_nettype none
`include "tbu_params.svh"
module tbu_timer_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TBU_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan0_pin_in,
    input wire logic chan0_pin_out,
    input wire logic chan0_pin_oe,
    input wire logic chan1_pin_in,
    input wire logic chan1_pin_out,
    input wire logic chan1_pin_oe,
    input wire logic irq
);
    ////////////////////////////////////////
    logic acc; // apb access phase
    logic bad; // unmapped or misaligned address
    logic [5:0] sh0; // channel 0 control shadow
    logic [5:0] sh1; // channel 1 control shadow, no link bit there
    assign acc = psel && penable;
    assign bad = (paddr[1:0] != 2'h0) || (paddr > `TBU_OFS_CH1_VAL);
    // shadows land on the same edge as the design's own control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh0 <= 6'h00;
            sh1 <= 6'h00;
        end else if (acc && pwrite && paddr == `TBU_OFS_CH0_CTL) begin
            sh0 <= pwdata[5:0];
        end else if (acc && pwrite && paddr == `TBU_OFS_CH1_CTL) begin
            sh1 <= {1'b0, pwdata[4:0]};
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // reset itself is the cause here, so this one is never disabled
    property p_rst_vals;
        disable iff (1'b0)
        !rst_n |=> !irq && !chan0_pin_oe && !chan1_pin_oe && chan0_pin_out && chan1_pin_out;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs wrong after reset");
    property p_err;
        acc && bad |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("bad address not refused");
    property p_ok;
        acc && !bad |-> pready && !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("good address refused");
    property p_cnt_hi;
        acc && !pwrite && paddr == `TBU_OFS_COUNT |-> prdata[31:16] == 16'h0000;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count wider than 16 bits");
    property p_link_oe;
        sh0[5] |-> !chan1_pin_oe;
    endproperty
    a_link_oe: assert property (p_link_oe) else $error("pin 1 driven while linked");
    property p_cap_oe;
        sh0[5:4] == 2'h0 || sh0[3:2] == 2'h0 |-> !chan0_pin_oe;
    endproperty
    a_cap_oe: assert property (p_cap_oe) else $error("pin 0 driven in capture");
    property p_cmp_oe;
        sh0[5:4] != 2'h0 && sh0[3:2] != 2'h0 |-> chan0_pin_oe;
    endproperty
    a_cmp_oe: assert property (p_cmp_oe) else $error("pin 0 not driven");
    property p_ch1_oe;
        !sh0[5] && sh1[4] && sh1[3:2] != 2'h0 |-> chan1_pin_oe;
    endproperty
    a_ch1_oe: assert property (p_ch1_oe) else $error("pin 1 not driven");
    property p_preset;
        sh0[3:2] == 2'h0 && $stable(sh0) |-> chan0_pin_out == !sh0[4];
    endproperty
    a_preset: assert property (p_preset) else $error("preset level wrong");
    c_err: cover property (acc && bad);
    c_link: cover property (sh0[5] && chan0_pin_oe);
    c_rise: cover property ($rose(chan0_pin_out) && chan0_pin_oe);
endmodule
bind tbu_timer tbu_timer_props i_props (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan0_pin_in(chan0_pin_in),
    .chan0_pin_out(chan0_pin_out), .chan0_pin_oe(chan0_pin_oe), .chan1_pin_in(chan1_pin_in),
    .chan1_pin_out(chan1_pin_out), .chan1_pin_oe(chan1_pin_oe), .irq(irq));
`default_nettype wire

// File: tb/tbu_pin_drv.sv
// Purpose: far-side signal source on one channel pin
// Assumes: the far side never fights the timer's driver
// Notes: the delay keeps edges off the clock edge, as a real source would
`timescale 1ns/1ps
`default_nettype none
module tbu_pin_drv (
    input wire logic lvl,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    // wire level: the timer while it drives, else the far side's level
    assign #7 pin_in = pin_oe ? pin_out : lvl;
endmodule
`default_nettype wire

// File: tb/tbu_timer_tb_top.sv
// Purpose: self-checking bench for tbu_timer
// Assumes: 25 MHz clock, zero-wait apb slave
// Notes: the counter is frozen before captures so expected values are exact
`timescale 1ns/1ps
`default_nettype none
`include "tbu_params.svh"
module tbu_timer_tb_top;
    localparam logic [4:0] A_CT = `TBU_OFS_CTRL;
    localparam logic [4:0] A_CN = `TBU_OFS_COUNT;
    localparam logic [4:0] A_MD = `TBU_OFS_MODULO;
    localparam logic [4:0] A_C0 = `TBU_OFS_CH0_CTL;
    localparam logic [4:0] A_C1 = `TBU_OFS_CH1_CTL;
    localparam logic [4:0] A_V0 = `TBU_OFS_CH0_VAL;
    localparam logic [4:0] A_V1 = `TBU_OFS_CH1_VAL;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] lvl = 2'h0; // far-side pin levels
    wire [1:0] p_in;
    wire [1:0] p_out;
    wire [1:0] p_oe;
    logic [31:0] rd; // last read data
    logic [31:0] h; // frozen count
    logic [31:0] ex; // expected value
    logic serr; // last slave error
    int error_cnt = 0;
    int total_checks = 0;
    always #20 clk = ~clk;
    ////////////////////////////////////////
    tbu_timer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan0_pin_in(p_in[0]), .chan0_pin_out(p_out[0]),
        .chan0_pin_oe(p_oe[0]), .chan1_pin_in(p_in[1]), .chan1_pin_out(p_out[1]),
        .chan1_pin_oe(p_oe[1]), .irq(irq));
    tbu_pin_drv i_pin0 (.lvl(lvl[0]), .pin_out(p_out[0]), .pin_oe(p_oe[0]), .pin_in(p_in[0]));
    tbu_pin_drv i_pin1 (.lvl(lvl[1]), .pin_out(p_out[1]), .pin_oe(p_oe[1]), .pin_in(p_in[1]));
    ////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; read data and error are taken at the ready edge only
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            finish_test();
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // a hang anywhere ends the run as a failure
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, A_CT, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        xfer(1'b0, A_C0, 32'h0);
        chk("ch0 ctl reset", rd, 32'h0);
        // refused places: unmapped read, misaligned write must not land
        xfer(1'b0, 5'h1C, 32'h0);
        chk("unmapped err", serr, 1);
        chk("unmapped data", rd, 32'h0);
        xfer(1'b1, 5'h0A, 32'h1234);
        chk("misaligned err", serr, 1);
        xfer(1'b0, A_MD, 32'h0);
        chk("modulo reset", rd, 32'h0000FFFF);
        // back-to-back reads latch three cycles apart and do not upset counting
        xfer(1'b0, A_CN, 32'h0);
        h = rd;
        xfer(1'b0, A_CN, 32'h0);
        chk("count step", rd - h, 32'h3);
        // every rate from a cleared prescaler; rate 7 stays stopped
        for (int r = 0; r < 8; r++) begin
            xfer(1'b1, A_CT, 32'h10 | r);
            repeat (256) @(posedge clk);
            xfer(1'b0, A_CN, 32'h0);
            ex = (r == 7) ? 32'h0 : (32'd258 >> r);
            chk("rate count", (rd + 2 >= ex) && (rd <= ex + 2), 1);
        end
        xfer(1'b1, A_CT, 32'h20);
        xfer(1'b0, A_CN, 32'h0);
        h = rd;
        repeat (4) @(posedge clk);
        xfer(1'b0, A_CN, 32'h0);
        chk("halted count", rd, h);
        xfer(1'b1, A_CT, 32'h30);
        xfer(1'b0, A_CN, 32'h0);
        chk("cleared count", rd, 32'h0);
        // short modulo: wrap flag, interrupt, restart from zero
        xfer(1'b1, A_MD, 32'h9);
        xfer(1'b1, A_CT, 32'h50);
        repeat (12) @(posedge clk);
        xfer(1'b0, A_CT, 32'h0);
        chk("wrap flag", rd[7], 1);
        chk("wrap irq", irq, 1);
        xfer(1'b0, A_CN, 32'h0);
        chk("count in range", rd < 32'hA, 1);
        xfer(1'b1, A_CT, 32'h60);
        @(negedge clk);
        chk("irq cleared", irq, 0);
        // freeze a nonzero count, then capture on every edge kind
        xfer(1'b1, A_MD, 32'hFFFF);
        xfer(1'b1, A_CT, 32'h10);
        xfer(1'b1, A_CT, 32'h20);
        xfer(1'b0, A_CN, 32'h0);
        h = rd;
        for (int e = 1; e < 4; e++) begin
            for (int d = 0; d < 2; d++) begin
                xfer(1'b1, A_V0, 32'h0);
                xfer(1'b1, A_C0, 32'h40 | (e << 2));
                lvl[0] <= ~lvl[0];
                repeat (5) @(posedge clk);
                ex = lvl[0] ? e & 1 : (e >> 1) & 1;
                xfer(1'b0, A_V0, 32'h0);
                chk("capture value", rd, ex[0] ? h : 32'h0);
                xfer(1'b0, A_C0, 32'h0);
                chk("capture flag", rd[7], ex[0]);
                chk("capture irq", irq, ex[0]);
            end
        end
        // flag still set: a new edge overwrites the old value
        xfer(1'b1, A_CT, 32'h0);
        xfer(1'b1, A_CT, 32'h20);
        xfer(1'b0, A_CN, 32'h0);
        h = rd;
        lvl[0] <= ~lvl[0];
        repeat (5) @(posedge clk);
        xfer(1'b0, A_V0, 32'h0);
        chk("overwrite", rd, h);
        // compare actions clear, set, toggle on a 16-count period
        xfer(1'b1, A_MD, 32'hF);
        xfer(1'b1, A_V0, 32'h5);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, A_CT, 32'h30);
            xfer(1'b1, A_C0, i == 0 ? 32'h18 : i == 1 ? 32'h1C : 32'h14);
            xfer(1'b1, A_CT, 32'h10);
            repeat (8) @(posedge clk);
            xfer(1'b1, A_CT, 32'h20);
            chk("compare pin", p_out[0], i == 1);
            xfer(1'b0, A_C0, 32'h0);
            chk("compare flag", rd[7], 1);
        end
        // no match reachable: only the wrap may toggle the pin
        xfer(1'b1, A_CT, 32'h30);
        xfer(1'b1, A_V0, 32'h20);
        xfer(1'b1, A_C0, 32'h1A);
        xfer(1'b1, A_CT, 32'h10);
        repeat (16) @(posedge clk);
        xfer(1'b1, A_CT, 32'h20);
        chk("wrap toggle", p_out[0], 1);
        // linked: channel 0 value first, channel 1 after the wrap
        xfer(1'b1, A_CT, 32'h30);
        xfer(1'b1, A_C1, 32'h5C);
        xfer(1'b1, A_C0, 32'h28);
        xfer(1'b1, A_V1, 32'h5);
        xfer(1'b1, A_CT, 32'h10);
        repeat (6) @(posedge clk);
        xfer(1'b0, A_C0, 32'h0);
        chk("linked first period", rd[7], 0);
        chk("pin 1 released", p_oe[1], 0);
        chk("ch1 irq ignored", irq, 0);
        repeat (20) @(posedge clk);
        xfer(1'b0, A_C0, 32'h0);
        chk("linked handover", rd[7], 1);
        finish_test();
    end
endmodule
`default_nettype wire
